// File: core/flash_cmd_pkg.sv
package flash_cmd_pkg;

   // ----------------------------------------
   // Register map and field positions
   // ----------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_INDEX = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam int STAT_COMMAND_COMPLETE_FLAG = 7;
   localparam int STAT_ACCESS_ERROR_FLAG = 5;
   localparam int STAT_PROTECTION_VIOLATION_FLAG = 4;
   localparam int STAT_VERR = 1;
   localparam int STAT_VUNC = 0;
   localparam int MODE_SPECIAL = 0;
   localparam int MODE_SECURED = 1;
   localparam int MODE_PROT = 2;
   localparam logic COMMAND_COMPLETE_FLAG_RST = 1'b1;
   localparam logic [2:0] INDEX_RST = 3'h0;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam int CMD_WORDS = 6;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_EV_ALL = 8'h01;
   localparam logic [7:0] CMD_EV_BLK = 8'h02;
   localparam logic [7:0] CMD_EV_PSEC = 8'h03;
   localparam logic [7:0] CMD_RD_ONCE = 8'h04;
   localparam logic [7:0] CMD_PGM_P = 8'h06;
   localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
   localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
   localparam logic [7:0] CMD_ERASE_PSEC = 8'h0A;
   localparam logic [7:0] CMD_UNSECURE = 8'h0B;
   localparam logic [7:0] CMD_KEY = 8'h0C;
   localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
   localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
   localparam logic [7:0] CMD_EV_DSEC = 8'h10;
   localparam logic [7:0] CMD_PGM_D = 8'h11;
   localparam logic [7:0] CMD_ERASE_DSEC = 8'h12;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } arr_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic corr;
      logic uncorr;
   } arr_rsp_t;

   typedef struct packed {
      logic start;
      logic [7:0] cmd;
      logic [15:0] w1;
      logic [15:0] w2;
   } eng_req_t;

   typedef struct packed {
      logic done;
      logic verr;
      logic vunc;
   } eng_rsp_t;

   // Tells whether a code may run in the given chip mode and security state.
   function automatic logic cmd_allowed(logic [7:0] c, logic special, logic secured);
      case (c)
         CMD_EV_ALL, CMD_EV_BLK: return 1'b1;
         CMD_ERASE_ALL, CMD_UNSECURE: return special;
         CMD_KEY: return !special;
         CMD_FIELD_MARGIN: return special && !secured;
         CMD_EV_PSEC, CMD_RD_ONCE, CMD_PGM_P, CMD_PGM_ONCE, CMD_ERASE_BLK,
         CMD_ERASE_PSEC, CMD_USER_MARGIN, CMD_EV_DSEC, CMD_PGM_D,
         CMD_ERASE_DSEC: return !(special && secured);
         default: return 1'b0;
      endcase
   endfunction

endpackage

// File: core/cmd_obj_mem.sv
`timescale 1ns/1ps
`default_nettype none

module cmd_obj_mem #(
   parameter int WORDS = 6,
   parameter int W = 16
) (
   input wire logic ref_clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic we, // Write strobe.
   input wire logic [2:0] waddr, // Write word index.
   input wire logic [W-1:0] wdata, // Write data.
   input wire logic [2:0] raddr, // Read word index.
   output logic [W-1:0] rdata_q // Registered read data.
);

   // The three-bit indexes reach at most eight words.
   if (WORDS < 1 || WORDS > 8 || W < 1) begin : g_chk
      $error("cmd_obj_mem: size out of range");
   end

   logic [W-1:0] mem_q [WORDS];
   logic [W-1:0] rdata_d;

   // Out-of-range indexes read as zero.
   always_comb begin
      rdata_d = '0;
      if (int'(raddr) < WORDS) begin
         rdata_d = mem_q[raddr];
      end
   end

   // Storage has no reset; only the read register does.
   always_ff @(posedge ref_clk) begin
      if (we && int'(waddr) < WORDS) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Read data leave through a register.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

endmodule

`default_nettype wire

// File: core/flash_cmd_ctrl.sv
// Functional notes
// R01: Sixteen defined command codes are decoded.
// R02: Full erase and unsecure only in special mode.
// R03: Backdoor key check only in normal mode.
// R04: Secured special mode allows four commands only.
// R05: Field margin only unsecured special mode.
// R06: Normal mode rejects erase-all, unsecure, field margin.
// R07: Verify-all checks every program and data block.
// R08: Verify-block checks one selected program block.
// R09: Verify-section checks count words from start.
// R10: Software writes nothing while full erase runs.
// R11: Complete flag sets only after erase finishes.
// R12: Full erase with nonzero index sets access error.
// R13: Disallowed command in mode sets access error.
// R14: Full erase with protection sets protection violation.
// R15: Any verify error sets verify error flag.
// R16: Uncorrectable verify error sets uncorrectable flag.
// R17: Clearing complete flag launches; device sets it again.
// R18: Undefined codes set access error, never start.
// R19: Failed launch check sets complete flag at once.
`timescale 1ns/1ps
`default_nettype none

module flash_cmd_ctrl
   import flash_cmd_pkg::*;
#(
   parameter int NUM_PBLK = 4,
   parameter int BLOCK_WORDS = 8192,
   parameter int DFLASH_WORDS = 2048
) (
   input wire logic ref_clk, // System clock, 100 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic hsel, // AHB slave select.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write.
   input wire logic [2:0] hsize, // AHB size, word only.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hready, // AHB bus ready.
   output logic hreadyout, // AHB slave ready.
   output logic hresp, // AHB response, always OKAY.
   output logic [31:0] hrdata, // AHB read data.
   output arr_req_t arr_req, // Array read request.
   input wire arr_rsp_t arr_rsp, // Array read answer.
   output eng_req_t eng_req, // Program and erase engine launch.
   input wire eng_rsp_t eng_rsp // Engine completion.
);

   localparam int PWORDS = NUM_PBLK * BLOCK_WORDS;
   localparam int ALL_WORDS = PWORDS + DFLASH_WORDS;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (NUM_PBLK < 1 || NUM_PBLK > 4 || BLOCK_WORDS < 1 || ALL_WORDS > 65536) begin : g_chk
      $error("flash_cmd_ctrl: array geometry out of range");
   end

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_LOAD0 = 7'b0000010,
      ST_LOAD1 = 7'b0000100,
      ST_LOAD2 = 7'b0001000,
      ST_CHECK = 7'b0010000,
      ST_VREAD = 7'b0100000,
      ST_VWAIT = 7'b1000000
   } st_t;

   logic eng_run_q, eng_run_d;
   st_t st_q, st_d;
   logic dp_q, dp_d, dpw_q, dpw_d, rdy_q, rdy_d;
   logic [7:0] dpa_q, dpa_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic command_complete_flag_q, command_complete_flag_d, access_error_flag_q, access_error_flag_d, protection_violation_flag_q, protection_violation_flag_d;
   logic verr_q, verr_d, vunc_q, vunc_d;
   logic [2:0] idx_q, idx_d, mode_q, mode_d;
   logic [15:0] w0_q, w0_d, w1_q, w1_d;
   logic [15:0] vaddr_q, vaddr_d;
   logic [16:0] vcnt_q, vcnt_d;
   arr_req_t arr_q, arr_d;
   eng_req_t eng_q, eng_d;
   logic [15:0] mem_rdata;
   logic [2:0] mem_raddr;
   logic mem_we, acc, wr_dp, launch;
   logic [7:0] cmd;
   logic special, secured, allowed;

   assign special = mode_q[MODE_SPECIAL];
   assign secured = mode_q[MODE_SECURED];
   assign cmd = w0_q[15:8];
   assign allowed = cmd_allowed(cmd, special, secured); // [R01] [R13]

   // ----------------------------------------
   // Command object storage
   // ----------------------------------------
   cmd_obj_mem #(.WORDS(CMD_WORDS), .W(16)) u_mem (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .we(mem_we),
      .waddr(idx_q),
      .wdata(hwdata[15:0]),
      .raddr(mem_raddr),
      .rdata_q(mem_rdata)
   );

   // Bus strobes and the read index of the command store.
   always_comb begin
      acc = hsel && htrans[1] && hready;
      wr_dp = dp_q && dpw_q;
      mem_we = wr_dp && dpa_q == OFS_DATA && command_complete_flag_q;
      launch = wr_dp && dpa_q == OFS_STATUS && command_complete_flag_q && hwdata[STAT_COMMAND_COMPLETE_FLAG]
         && !(access_error_flag_q && !hwdata[STAT_ACCESS_ERROR_FLAG]) && !(protection_violation_flag_q && !hwdata[STAT_PROTECTION_VIOLATION_FLAG]);
      unique case (st_q)
         ST_LOAD0: mem_raddr = 3'h0;
         ST_LOAD1: mem_raddr = 3'h1;
         ST_LOAD2: mem_raddr = 3'h2;
         default: mem_raddr = idx_q;
      endcase
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Bus slave, flags, launch checks and the erase-verify walk.
   always_comb begin
      dp_d = dp_q;
      dpw_d = dpw_q;
      dpa_d = dpa_q;
      rdy_d = rdy_q;
      hrdata_d = hrdata_q;
      command_complete_flag_d = command_complete_flag_q;
      access_error_flag_d = access_error_flag_q;
      protection_violation_flag_d = protection_violation_flag_q;
      verr_d = verr_q;
      vunc_d = vunc_q;
      idx_d = idx_q;
      mode_d = mode_q;
      w0_d = w0_q;
      w1_d = w1_q;
      vaddr_d = vaddr_q;
      vcnt_d = vcnt_q;
      st_d = st_q;
      eng_run_d = eng_run_q;
      arr_d = '0;
      eng_d = '0;
      // Every transfer gets exactly one wait state.
      if (acc) begin
         dp_d = 1'b1;
         dpw_d = hwrite;
         dpa_d = haddr[7:0];
         rdy_d = 1'b0;
      end else if (dp_q) begin
         dp_d = 1'b0;
         rdy_d = 1'b1;
         hrdata_d = '0;
         if (!dpw_q) begin
            unique case (dpa_q)
               OFS_STATUS: begin
                  hrdata_d[STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag_q;
                  hrdata_d[STAT_ACCESS_ERROR_FLAG] = access_error_flag_q;
                  hrdata_d[STAT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_q;
                  hrdata_d[STAT_VERR] = verr_q;
                  hrdata_d[STAT_VUNC] = vunc_q;
               end
               OFS_INDEX: hrdata_d[2:0] = idx_q;
               OFS_DATA: hrdata_d[15:0] = mem_rdata;
               OFS_MODE: hrdata_d[2:0] = mode_q;
               default: hrdata_d = '0;
            endcase
         end
      end
      // Control writes are ignored while a command runs.
      if (wr_dp && command_complete_flag_q) begin
         if (dpa_q == OFS_INDEX) begin
            idx_d = hwdata[2:0];
         end
         if (dpa_q == OFS_MODE) begin
            mode_d = hwdata[2:0];
         end
         if (dpa_q == OFS_STATUS) begin
            if (hwdata[STAT_ACCESS_ERROR_FLAG]) access_error_flag_d = 1'b0;
            if (hwdata[STAT_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_d = 1'b0;
         end
      end
      if (launch) begin
         command_complete_flag_d = 1'b0; // [R17]
         verr_d = 1'b0;
         vunc_d = 1'b0;
         st_d = ST_LOAD0;
      end
      unique case (st_q)
         ST_IDLE: begin
            if (eng_run_q && eng_rsp.done) begin
               eng_run_d = 1'b0;
               command_complete_flag_d = 1'b1; // [R11] [R17]
               verr_d = eng_rsp.verr;
               vunc_d = eng_rsp.vunc;
            end
         end
         ST_LOAD0: st_d = ST_LOAD1;
         ST_LOAD1: begin
            w0_d = mem_rdata;
            st_d = ST_LOAD2;
         end
         ST_LOAD2: begin
            w1_d = mem_rdata;
            st_d = ST_CHECK;
         end
         ST_CHECK: begin
            st_d = ST_IDLE;
            if (!allowed) begin
               access_error_flag_d = 1'b1; // [R02] [R03] [R04] [R05] [R06] [R13] [R18]
               command_complete_flag_d = 1'b1; // [R19]
            end else if (cmd == CMD_ERASE_ALL && idx_q != 3'h0) begin
               access_error_flag_d = 1'b1; // [R12]
               command_complete_flag_d = 1'b1; // [R19]
            end else if (cmd == CMD_ERASE_ALL && mode_q[MODE_PROT]) begin
               protection_violation_flag_d = 1'b1; // [R14]
               command_complete_flag_d = 1'b1; // [R19]
            end else if (cmd == CMD_EV_ALL) begin
               vaddr_d = 16'h0000; // [R07]
               vcnt_d = 17'(ALL_WORDS);
               st_d = ST_VREAD;
            end else if (cmd == CMD_EV_BLK) begin
               vaddr_d = 16'(int'(w0_q[1:0]) * BLOCK_WORDS); // [R08]
               vcnt_d = 17'(BLOCK_WORDS);
               if (int'(w0_q[1:0]) >= NUM_PBLK) begin
                  access_error_flag_d = 1'b1;
                  command_complete_flag_d = 1'b1;
                  st_d = ST_IDLE;
               end else begin
                  st_d = ST_VREAD;
               end
            end else if (cmd == CMD_EV_PSEC || cmd == CMD_EV_DSEC) begin
               vaddr_d = w1_q; // [R09]
               vcnt_d = {1'b0, mem_rdata};
               if (mem_rdata == 16'h0000) begin
                  command_complete_flag_d = 1'b1;
               end else begin
                  st_d = ST_VREAD;
               end
            end else begin
               eng_d.start = 1'b1;
               eng_d.cmd = cmd;
               eng_d.w1 = w1_q;
               eng_d.w2 = mem_rdata;
               eng_run_d = 1'b1; // [R11]
            end
         end
         ST_VREAD: begin
            arr_d.rd = 1'b1;
            arr_d.addr = vaddr_q;
            st_d = ST_VWAIT;
         end
         ST_VWAIT: begin
            if (arr_rsp.valid) begin
               if (arr_rsp.data != ERASED_WORD || arr_rsp.corr || arr_rsp.uncorr) begin
                  verr_d = 1'b1; // [R15]
               end
               if (arr_rsp.uncorr) begin
                  vunc_d = 1'b1; // [R16]
               end
               vaddr_d = vaddr_q + 16'h0001;
               vcnt_d = vcnt_q - 17'h00001;
               if (vcnt_q == 17'h00001) begin
                  command_complete_flag_d = 1'b1; // [R07] [R17]
                  st_d = ST_IDLE;
               end else begin
                  st_d = ST_VREAD;
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   // Registers only; all decisions are made above.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_q <= 1'b0;
         dpw_q <= 1'b0;
         dpa_q <= 8'h00;
         rdy_q <= 1'b1;
         hrdata_q <= 32'h00000000;
         command_complete_flag_q <= COMMAND_COMPLETE_FLAG_RST;
         access_error_flag_q <= 1'b0;
         protection_violation_flag_q <= 1'b0;
         verr_q <= 1'b0;
         vunc_q <= 1'b0;
         idx_q <= INDEX_RST;
         mode_q <= MODE_RST;
         w0_q <= 16'h0000;
         w1_q <= 16'h0000;
         vaddr_q <= 16'h0000;
         vcnt_q <= 17'h00000;
         st_q <= ST_IDLE;
         eng_run_q <= 1'b0;
         arr_q <= '0;
         eng_q <= '0;
      end else begin
         dp_q <= dp_d;
         dpw_q <= dpw_d;
         dpa_q <= dpa_d;
         rdy_q <= rdy_d;
         hrdata_q <= hrdata_d;
         command_complete_flag_q <= command_complete_flag_d;
         access_error_flag_q <= access_error_flag_d;
         protection_violation_flag_q <= protection_violation_flag_d;
         verr_q <= verr_d;
         vunc_q <= vunc_d;
         idx_q <= idx_d;
         mode_q <= mode_d;
         w0_q <= w0_d;
         w1_q <= w1_d;
         vaddr_q <= vaddr_d;
         vcnt_q <= vcnt_d;
         st_q <= st_d;
         eng_run_q <= eng_run_d;
         arr_q <= arr_d;
         eng_q <= eng_d;
      end
   end

   assign hreadyout = rdy_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign arr_req = arr_q;
   assign eng_req = eng_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_launch_drop: assert property (launch |=> !command_complete_flag_q ##1 st_q == ST_LOAD1) // [R17]
      else $error("launch did not clear the complete flag");
   chk_mode_reject: assert property (st_q == ST_CHECK && !allowed
      |=> access_error_flag_q && command_complete_flag_q && !eng_q.start) // [R13]
      else $error("disallowed command was not rejected");
   chk_erase_index: assert property (st_q == ST_CHECK && allowed && cmd == CMD_ERASE_ALL
      && idx_q != 3'h0 |=> access_error_flag_q && !eng_q.start && command_complete_flag_q) // [R12]
      else $error("erase-all with nonzero index not refused");
   chk_erase_prot: assert property (st_q == ST_CHECK && allowed && cmd == CMD_ERASE_ALL
      && idx_q == 3'h0 && mode_q[MODE_PROT] |=> protection_violation_flag_q && !eng_q.start) // [R14]
      else $error("protected erase-all not refused");
   chk_engine_gate: assert property (eng_q.start
      |-> cmd_allowed(eng_q.cmd, special, secured) && !command_complete_flag_q) // [R06]
      else $error("engine started for a disallowed command");
   chk_command_complete_flag_busy: assert property (eng_run_q && !eng_rsp.done |=> !command_complete_flag_q) // [R11]
      else $error("complete flag set before engine finished");
   chk_verify_err: assert property (st_q == ST_VWAIT && arr_rsp.valid
      && (arr_rsp.data != ERASED_WORD || arr_rsp.corr) |=> verr_q) // [R15]
      else $error("verify error not flagged");
   chk_verify_unc: assert property (st_q == ST_VWAIT && arr_rsp.valid && arr_rsp.uncorr
      |=> vunc_q && verr_q) // [R16]
      else $error("uncorrectable verify error not flagged");
   chk_bus_wait: assert property (acc |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");

   cov_erase_all: cover property (eng_q.start && eng_q.cmd == CMD_ERASE_ALL);
   cov_verify_fail: cover property (st_q == ST_VWAIT ##1 verr_q && command_complete_flag_q);
   cov_reject: cover property (st_q == ST_CHECK && !allowed);

endmodule

`default_nettype wire

// File: tb/tb_flash_command_mode_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tb_flash_command_mode_checker
   import flash_cmd_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic rst_n, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic hreadyout, hresp;
   wire logic hready;
   arr_req_t arr_req;
   arr_rsp_t arr_rsp;
   eng_req_t eng_req;
   eng_rsp_t eng_rsp;
   int n_errors = 0;
   int checks = 0;
   int rd_cnt = 0;
   int st_cnt = 0;
   int eng_wait = 0;
   logic [15:0] bad_addr, bad_data;
   logic bad_corr, bad_unc, eng_verr, eng_vunc;
   logic [7:0] eng_cmd;
   logic [15:0] eng_w1, eng_w2;
   logic [7:0] codes [21] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h00, 8'h05, 8'h0F, 8'h13, 8'hFF};

   // The single slave's ready is the bus ready.
   assign hready = hreadyout;

   // The clock toggles every half period of 5 ns.
   always #5 ref_clk = ~ref_clk;

   flash_cmd_ctrl #(.NUM_PBLK(4), .BLOCK_WORDS(4), .DFLASH_WORDS(4)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .arr_req(arr_req),
      .arr_rsp(arr_rsp), .eng_req(eng_req), .eng_rsp(eng_rsp));

   // ----------------------------------------
   // Array and engine responders
   // ----------------------------------------
   // The array answers one cycle after a read; idle data keeps toggling.
   always @(posedge ref_clk) begin
      arr_rsp.valid <= arr_req.rd;
      arr_rsp.data <= (arr_req.rd === 1'b1) ?
         ((arr_req.addr === bad_addr) ? bad_data : ERASED_WORD) : ~arr_rsp.data;
      arr_rsp.corr <= (arr_req.rd === 1'b1) && (arr_req.addr === bad_addr) && bad_corr;
      arr_rsp.uncorr <= (arr_req.rd === 1'b1) && (arr_req.addr === bad_addr) && bad_unc;
      if (arr_req.rd === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
   end

   // The engine finishes twelve cycles after its start pulse.
   always @(posedge ref_clk) begin
      eng_rsp.done <= (eng_wait == 1);
      eng_rsp.verr <= (eng_wait == 1) && eng_verr;
      eng_rsp.vunc <= (eng_wait == 1) && eng_vunc;
      if (eng_req.start === 1'b1) begin
         st_cnt <= st_cnt + 1;
         eng_wait <= 12;
         eng_cmd <= eng_req.cmd;
         eng_w1 <= eng_req.w1;
         eng_w2 <= eng_req.w2;
      end else if (eng_wait > 0) begin
         eng_wait <= eng_wait - 1;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compares a value with its expectation and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic results();
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One single AHB-Lite transfer; waits for ready at both phases.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? wd : 32'h0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      check(hresp, 0, "response");
      if (n >= 100) begin
         check(n, 0, "bus hang");
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   // Loads the command words, launches and polls until complete.
   task automatic run(input logic [7:0] c, input logic [7:0] lo, input logic [15:0] w1,
                      input logic [15:0] w2, input logic [2:0] ix, output logic [31:0] st);
      int n;
      n = 0;
      wr(OFS_INDEX, 0);
      wr(OFS_DATA, {16'h0, c, lo});
      wr(OFS_INDEX, 1);
      wr(OFS_DATA, {16'h0, w1});
      wr(OFS_INDEX, 2);
      wr(OFS_DATA, {16'h0, w2});
      wr(OFS_INDEX, {29'h0, ix});
      wr(OFS_STATUS, 32'hB0);
      do begin
         ahb(1'b0, OFS_STATUS, 0, st);
         n++;
      end while (st[STAT_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 200);
      check(st[STAT_COMMAND_COMPLETE_FLAG], 1, "complete flag");
      check(eng_wait, 0, "complete before engine done");
   endtask

   // Runs one verify case and compares flags and array read count.
   task automatic vcase(input logic [7:0] c, input logic [7:0] lo, input logic [15:0] w1,
                        input logic [15:0] w2, input logic [15:0] ba, input logic [15:0] bd,
                        input logic co, input logic un, input logic ev, input logic eu,
                        input int nr);
      logic [31:0] st;
      int r0;
      bad_addr <= ba;
      bad_data <= bd;
      bad_corr <= co;
      bad_unc <= un;
      eng_verr <= ev;
      eng_vunc <= eu;
      r0 = rd_cnt;
      run(c, lo, w1, w2, 3'h0, st);
      check(st[STAT_VERR], ev, "verify error");
      check(st[STAT_VUNC], eu, "uncorrectable");
      check(rd_cnt - r0, nr, "array reads");
   endtask

   // Acceptance of a code in a mode, worked out from the command table.
   function automatic logic ok(input logic [7:0] c, input logic sp, input logic sc);
      case (c)
         8'h01, 8'h02: return 1'b1;
         8'h08, 8'h0B: return sp;
         8'h0C: return !sp;
         8'h0E: return sp && !sc;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11,
         8'h12: return !(sp && sc);
         default: return 1'b0;
      endcase
   endfunction

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   // Resets the block and walks through the scenarios.
   initial begin
      logic [31:0] st;
      logic e;
      int r0;
      int s0;
      rst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      arr_rsp = '0;
      eng_rsp = '0;
      bad_addr = 16'h7FFF;
      bad_data = 16'h0000;
      bad_corr = 1'b0;
      bad_unc = 1'b0;
      eng_verr = 1'b0;
      eng_vunc = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      ahb(1'b0, OFS_STATUS, 0, st);
      check(st, 32'h80, "status after reset");
      ahb(1'b0, 8'h40, 0, st);
      check(st, 0, "unmapped read");
      // Each defined code and five undefined ones in every mode and security combination.
      for (int m = 0; m < 4; m++) begin
         wr(OFS_MODE, m);
         for (int k = 0; k < 21; k++) begin
            e = ok(codes[k], m[0], m[1]);
            r0 = rd_cnt;
            s0 = st_cnt;
            run(codes[k], 8'h00, 16'h0, 16'h0, 3'h0, st);
            check(st[STAT_ACCESS_ERROR_FLAG], !e, "mode acceptance");
            if (!e) begin
               check(rd_cnt - r0 + st_cnt - s0, 0, "rejected started");
            end else if (codes[k] == CMD_EV_ALL) begin
               check(rd_cnt - r0, 20, "verify all reads");
            end else if (!(codes[k] inside {8'h01, 8'h02, 8'h03, 8'h10})) begin
               check(st_cnt - s0, 1, "engine start");
               check(eng_cmd, codes[k], "engine code");
            end
         end
      end
      // Full erase with a nonzero index, then with protection set.
      wr(OFS_MODE, 1);
      s0 = st_cnt;
      run(CMD_ERASE_ALL, 8'h00, 16'h0, 16'h0, 3'h1, st);
      check(st[STAT_ACCESS_ERROR_FLAG], 1, "index not zero");
      wr(OFS_MODE, 5);
      run(CMD_ERASE_ALL, 8'h00, 16'h0, 16'h0, 3'h0, st);
      check(st[5:4], 2'h1, "protection violation");
      check(st_cnt - s0, 0, "erase refused");
      // Verify walks with faults placed inside and outside their range.
      wr(OFS_MODE, 0);
      vcase(CMD_EV_ALL, 8'h00, 0, 0, 16'd19, 16'hFFFE, 0, 0, 1, 0, 20);
      vcase(CMD_EV_ALL, 8'h00, 0, 0, 16'd0, 16'hFFFF, 0, 1, 1, 1, 20);
      vcase(CMD_EV_ALL, 8'h00, 0, 0, 16'h7FFF, 16'h0, 0, 0, 0, 0, 20);
      vcase(CMD_EV_BLK, 8'h02, 0, 0, 16'd8, 16'h0, 0, 0, 1, 0, 4);
      vcase(CMD_EV_BLK, 8'h01, 0, 0, 16'd8, 16'h0, 0, 0, 0, 0, 4);
      vcase(CMD_EV_BLK, 8'h03, 0, 0, 16'd12, 16'hFFFF, 1, 0, 1, 0, 4);
      vcase(CMD_EV_PSEC, 8'h00, 6, 3, 16'd9, 16'h0, 0, 0, 0, 0, 3);
      vcase(CMD_EV_PSEC, 8'h00, 6, 3, 16'd8, 16'h0, 0, 0, 1, 0, 3);
      vcase(CMD_EV_PSEC, 8'h00, 6, 0, 16'd6, 16'h0, 0, 0, 0, 0, 0);
      vcase(CMD_ERASE_BLK, 8'h00, 16'h1234, 16'h0056, 16'h7FFF, 16'h0, 0, 0, 1, 1, 0);
      check({eng_w1, eng_w2}, 32'h12340056, "engine words");
      results();
   end

   // Cuts a hang short after a span well beyond the expected run.
   initial begin
      repeat (50000) @(posedge ref_clk);
      n_errors++;
      results();
   end

endmodule

`default_nettype wire
